//--- hw/pfm_monitor.sv
/*
 * protection fault monitor: low-voltage, low-current, over-temperature and
 * mode-switch trips, output gate, buzzer, flashing message and interrupt.
 * assumes one 50 MHz clock, synchronous active-low reset, a classic wishbone
 * master and pins from outside the clock domain (synchronised here).
 */
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "pfm_map.svh"

// Functional notes
// (R1) low-voltage enabled: measured voltage under its level is a candidate fault.
// (R2) low-voltage faults ignored until output has been on longer than warm-up.
// (R3) low-voltage trip only after the condition outlasts its delay.
// (R4) low-voltage trip: output off, buzzer pulses, message flashes, status bit set.
// (R5) escape key or remote clear wipes low-voltage status and its message.
// (R6) low-current enabled: measured current under its level is a candidate fault.
// (R7) low-current faults ignored until output has been on longer than warm-up.
// (R8) low-current trip only after the condition outlasts its delay.
// (R9) low-current trip: output off, buzzer pulses, message flashes, status bit set.
// (R10) escape key or remote clear wipes low-current status and its message.
// (R11) temperature above 85 degrees shuts output down and shows its message.
// (R12) output-on requests refused while hot; on key works again after cooling.
// (R13) mode-switch protection selects constant current, constant voltage, or off.
// (R14) mode-switch trips after the loop stays in the chosen mode beyond its delay.
// (R15) shorter visits to the chosen mode neither trip nor switch output off.
// (R16) mode-switch trip: output off, buzzer pulses, message flashes, status bit set.
// (R17) every delay and warm-up timer restarts at zero when its condition lapses.
// (R18) a clear while the fault persists re-arms it to trip again after delay.
module pfm_monitor
    import pfm_pkg::*;
#(
    parameter int MW           = 16,
    parameter int TW           = 12,
    parameter int BLINK_CYCLES = `PFM_BLINK_MS * (`PFM_CLK_HZ / 1000)
) (
    input  wire logic          clock_in,
    input  wire logic          rst_n_in,
    input  wire logic          wb_cyc_in,
    input  wire logic          wb_stb_in,
    input  wire logic          wb_we_in,
    input  wire logic [7:0]    wb_adr_in,
    input  wire logic [3:0]    wb_sel_in,
    input  wire logic [31:0]   wb_dat_in,
    output logic      [31:0]   wb_dat_out,
    output logic               wb_ack_out,
    input  wire logic [MW-1:0] meas_voltage_in,
    input  wire logic [MW-1:0] meas_current_in,
    input  wire logic [TW-1:0] temperature_in,
    input  wire logic          constant_current_mode_in,
    input  wire logic          constant_voltage_mode_in,
    input  wire logic          esc_key_in,
    input  wire logic          on_key_in,
    output logic               output_enable_out,
    output logic               buzzer_out,
    output logic               msg_flash_out,
    output pfm_pkg::pfm_msg_e  msg_code_out,
    output logic               irq_out
);
    import pfm_pkg::*;

    // saturating timer step: counts while run is high, else back to zero
    function automatic logic [31:0] fn_step(input logic [31:0] cnt, input logic run);
        if (!run)
            return 32'h0000_0000;
        else if (cnt == 32'hffff_ffff)
            return cnt;
        else
            return cnt + 32'h0000_0001;
    endfunction

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] fn_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i])
                res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction

    // pin synchronisers, two stages each
    logic [MW-1:0] volt_s1, volt_s2, curr_s1, curr_s2;
    logic [TW-1:0] temp_s1, temp_s2;
    logic [3:0]    pin_s1, pin_s2;
    logic          esc_prev, on_prev;

    // register file
    logic [31:0] ctrl, lv_level, lv_delay, lv_warm, lc_level, lc_delay, lc_warm, ms_delay;
    logic [3:0]  status, mask;
    logic        out_on;

    // timers
    logic [31:0] on_time, lv_cnt, lc_cnt, ms_cnt;
    logic [31:0] blink_cnt;
    logic        blink;

    // decoded events
    logic        wr_req, ctrl_wr, status_wr;
    logic [31:0] ctrl_wdata;
    logic        esc_press, on_press, remote_clear, remote_on, remote_off, clear_req;
    logic        hot, ccm, cvm, lv_cond, lc_cond, ms_cond;
    logic        lv_trip, lc_trip, ms_trip, ot_trip;
    logic [3:0]  trip_vec;
    pfm_mode_e   ms_mode;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            volt_s1 <= '0;
            volt_s2 <= '0;
            curr_s1 <= '0;
            curr_s2 <= '0;
            temp_s1 <= '0;
            temp_s2 <= '0;
            pin_s1  <= 4'h0;
            pin_s2  <= 4'h0;
        end else begin
            volt_s1 <= meas_voltage_in;
            volt_s2 <= volt_s1;
            curr_s1 <= meas_current_in;
            curr_s2 <= curr_s1;
            temp_s1 <= temperature_in;
            temp_s2 <= temp_s1;
            pin_s1  <= {on_key_in, esc_key_in, constant_voltage_mode_in, constant_current_mode_in};
            pin_s2  <= pin_s1;
        end
    end

    // key edge detection on synchronised levels
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            esc_prev <= 1'b0;
            on_prev  <= 1'b0;
        end else begin
            esc_prev <= pin_s2[2];
            on_prev  <= pin_s2[3];
        end
    end

    // bus and event decode
    assign wr_req       = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out;
    assign ctrl_wr      = wr_req && (wb_adr_in == `PFM_CTRL_OFS);
    assign status_wr    = wr_req && (wb_adr_in == `PFM_STATUS_OFS);
    assign ctrl_wdata   = fn_merge(32'h0000_0000, wb_dat_in, wb_sel_in);
    assign remote_on    = ctrl_wr && ctrl_wdata[`PFM_CTRL_ON];
    assign remote_off   = ctrl_wr && ctrl_wdata[`PFM_CTRL_OFF];
    assign remote_clear = ctrl_wr && ctrl_wdata[`PFM_CTRL_CLEAR];
    assign esc_press    = pin_s2[2] && !esc_prev;
    assign on_press     = pin_s2[3] && !on_prev;
    assign clear_req    = esc_press || remote_clear;                       // R5 R10
    assign ccm          = pin_s2[0];
    assign cvm          = pin_s2[1];
    assign ms_mode      = pfm_mode_e'(ctrl[`PFM_CTRL_MODE_HI:`PFM_CTRL_MODE_LO]);

    // fault conditions
    assign hot     = temp_s2 > TW'(`PFM_OT_LIMIT_C);                        // R11
    assign lv_cond = out_on && ctrl[`PFM_CTRL_LV_EN]
                     && (32'(volt_s2) < lv_level)                           // R1
                     && (on_time > lv_warm);                                // R2
    assign lc_cond = out_on && ctrl[`PFM_CTRL_LC_EN]
                     && (32'(curr_s2) < lc_level)                           // R6
                     && (on_time > lc_warm);                                // R7
    always_comb begin
        unique case (ms_mode)                                               // R13
            PFM_MODE_CURR: ms_cond = out_on && ccm;
            PFM_MODE_VOLT: ms_cond = out_on && cvm;
            default:       ms_cond = 1'b0;
        endcase
    end

    // low-voltage, low-current and mode-switch trips fire once the condition outlasts its delay; over-temperature trips at once
    assign lv_trip  = lv_cond && (lv_cnt > lv_delay);                       // R3
    assign lc_trip  = lc_cond && (lc_cnt > lc_delay);                       // R8
    assign ms_trip  = ms_cond && (ms_cnt > ms_delay);                       // R14 R15
    assign ot_trip  = hot && !status[`PFM_ST_OT];
    assign trip_vec = {ms_trip, ot_trip, lc_trip, lv_trip};

    // timers: each resets as soon as its qualifying condition lapses
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            on_time <= 32'h0000_0000;
            lv_cnt  <= 32'h0000_0000;
            lc_cnt  <= 32'h0000_0000;
            ms_cnt  <= 32'h0000_0000;
        end else begin
            on_time <= fn_step(on_time, out_on);                            // R17
            lv_cnt  <= fn_step(lv_cnt, lv_cond);                            // R17
            lc_cnt  <= fn_step(lc_cnt, lc_cond);                            // R17
            ms_cnt  <= fn_step(ms_cnt, ms_cond);                            // R17
        end
    end

    // output gate: any trip or heat forces off; on refused while hot
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            out_on <= PFM_OUT_OFF;
        end else if (|trip_vec || hot || remote_off) begin
            out_on <= PFM_OUT_OFF;                                          // R4 R9 R11 R16
        end else if (on_press || remote_on) begin
            out_on <= PFM_OUT_ON;                                           // R12 R18
        end
    end

    // protection status: set by trips, cleared by escape, remote clear or w1c
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            status <= 4'h0;
        end else begin
            status <= (status & ~({4{clear_req}} | (status_wr ? wb_dat_in[3:0] : 4'h0)))
                      | trip_vec;                                           // R4 R5 R9 R10 R16
        end
    end

    // configuration registers
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ctrl     <= `PFM_CTRL_RST;
            lv_level <= `PFM_LEVEL_RST;
            lv_delay <= `PFM_TIME_RST;
            lv_warm  <= `PFM_TIME_RST;
            lc_level <= `PFM_LEVEL_RST;
            lc_delay <= `PFM_TIME_RST;
            lc_warm  <= `PFM_TIME_RST;
            ms_delay <= `PFM_TIME_RST;
            mask     <= `PFM_MASK_RST;
        end else if (wr_req) begin
            unique case (wb_adr_in)
                `PFM_CTRL_OFS:     ctrl     <= fn_merge(ctrl, wb_dat_in, wb_sel_in) & 32'h0000_000f;
                `PFM_LV_LEVEL_OFS: lv_level <= fn_merge(lv_level, wb_dat_in, wb_sel_in);
                `PFM_LV_DELAY_OFS: lv_delay <= fn_merge(lv_delay, wb_dat_in, wb_sel_in);
                `PFM_LV_WARM_OFS:  lv_warm  <= fn_merge(lv_warm, wb_dat_in, wb_sel_in);
                `PFM_LC_LEVEL_OFS: lc_level <= fn_merge(lc_level, wb_dat_in, wb_sel_in);
                `PFM_LC_DELAY_OFS: lc_delay <= fn_merge(lc_delay, wb_dat_in, wb_sel_in);
                `PFM_LC_WARM_OFS:  lc_warm  <= fn_merge(lc_warm, wb_dat_in, wb_sel_in);
                `PFM_MS_DELAY_OFS: ms_delay <= fn_merge(ms_delay, wb_dat_in, wb_sel_in);
                `PFM_MASK_OFS:     mask     <= wb_sel_in[0] ? wb_dat_in[3:0] : mask;
                default:           ctrl     <= ctrl;
            endcase
        end
    end

    // wishbone answer: ack one cycle after the strobe, data registered with it
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
            wb_dat_out <= 32'h0000_0000;
            if (wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out) begin
                unique case (wb_adr_in)
                    `PFM_CTRL_OFS:     wb_dat_out <= ctrl;
                    `PFM_LV_LEVEL_OFS: wb_dat_out <= lv_level;
                    `PFM_LV_DELAY_OFS: wb_dat_out <= lv_delay;
                    `PFM_LV_WARM_OFS:  wb_dat_out <= lv_warm;
                    `PFM_LC_LEVEL_OFS: wb_dat_out <= lc_level;
                    `PFM_LC_DELAY_OFS: wb_dat_out <= lc_delay;
                    `PFM_LC_WARM_OFS:  wb_dat_out <= lc_warm;
                    `PFM_MS_DELAY_OFS: wb_dat_out <= ms_delay;
                    `PFM_STATUS_OFS:   wb_dat_out <= {28'h0, status};
                    `PFM_MASK_OFS:     wb_dat_out <= {28'h0, mask};
                    `PFM_STATE_OFS:    wb_dat_out <= {28'h0, cvm, ccm, hot, out_on};
                    default:           wb_dat_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // blink timebase shared by buzzer and message flash
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            blink_cnt <= 32'h0000_0000;
            blink     <= 1'b0;
        end else if (blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
            blink_cnt <= 32'h0000_0000;
            blink     <= !blink;
        end else begin
            blink_cnt <= blink_cnt + 32'h0000_0001;
        end
    end

    // panel outputs: heat message first, then low voltage, low current, mode switch in that order
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            output_enable_out <= 1'b0;
            buzzer_out        <= 1'b0;
            msg_flash_out     <= 1'b0;
            msg_code_out      <= PFM_MSG_NONE;
            irq_out           <= 1'b0;
        end else begin
            output_enable_out <= out_on;
            buzzer_out        <= blink && |{status[`PFM_ST_MS], status[`PFM_ST_LC], status[`PFM_ST_LV]};
            msg_flash_out     <= blink && (|status || hot);
            irq_out           <= |(status & mask);
            if (hot || status[`PFM_ST_OT])
                msg_code_out <= PFM_MSG_OT;                                 // R11
            else if (status[`PFM_ST_LV])
                msg_code_out <= PFM_MSG_LV;                                 // R4
            else if (status[`PFM_ST_LC])
                msg_code_out <= PFM_MSG_LC;                                 // R9
            else if (status[`PFM_ST_MS])
                msg_code_out <= PFM_MSG_MS;                                 // R16
            else
                msg_code_out <= PFM_MSG_NONE;
        end
    end
endmodule

//--- hw/pfm_map.svh
/*
 * register offsets, field positions, reset values and timing figures of the
 * protection fault monitor.
 * assumes a 32-bit classic wishbone slave on a 50 MHz clock.
 */
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH

// byte offsets
`define PFM_CTRL_OFS      8'h00
`define PFM_LV_LEVEL_OFS  8'h04
`define PFM_LV_DELAY_OFS  8'h08
`define PFM_LV_WARM_OFS   8'h0c
`define PFM_LC_LEVEL_OFS  8'h10
`define PFM_LC_DELAY_OFS  8'h14
`define PFM_LC_WARM_OFS   8'h18
`define PFM_MS_DELAY_OFS  8'h1c
`define PFM_STATUS_OFS    8'h20
`define PFM_MASK_OFS      8'h24
`define PFM_STATE_OFS     8'h28

// control fields
`define PFM_CTRL_LV_EN    0
`define PFM_CTRL_LC_EN    1
`define PFM_CTRL_MODE_LO  2
`define PFM_CTRL_MODE_HI  3
`define PFM_CTRL_ON       4
`define PFM_CTRL_OFF      5
`define PFM_CTRL_CLEAR    6

// status and mask fields
`define PFM_ST_LV         0
`define PFM_ST_LC         1
`define PFM_ST_OT         2
`define PFM_ST_MS         3

// state register fields
`define PFM_STATE_OUT     0
`define PFM_STATE_HOT     1
`define PFM_STATE_CCM     2
`define PFM_STATE_CVM     3

// reset values
`define PFM_CTRL_RST      32'h0000_0000
`define PFM_LEVEL_RST     32'h0000_0000
`define PFM_TIME_RST      32'h0000_0000
`define PFM_MASK_RST      4'h0

// timing and thresholds
`define PFM_CLK_HZ        50000000
`define PFM_BLINK_MS      250
`define PFM_OT_LIMIT_C    12'h055

`endif

//--- hw/pfm_pkg.sv
/*
 * types shared by the protection fault monitor.
 * assumes pfm_map.svh holds the numeric constants.
 */
package pfm_pkg;
    typedef enum logic [1:0] {
        PFM_MODE_OFF  = 2'b00,
        PFM_MODE_CURR = 2'b01,
        PFM_MODE_VOLT = 2'b10,
        PFM_MODE_RSV  = 2'b11
    } pfm_mode_e;

    typedef enum logic [2:0] {
        PFM_MSG_NONE = 3'b000,
        PFM_MSG_LV   = 3'b001,
        PFM_MSG_LC   = 3'b010,
        PFM_MSG_OT   = 3'b011,
        PFM_MSG_MS   = 3'b100
    } pfm_msg_e;

    typedef enum logic {
        PFM_OUT_OFF = 1'b0,
        PFM_OUT_ON  = 1'b1
    } pfm_out_e;
endpackage

//--- tb/pfm_monitor_checker.sv
/* port checker for pfm_monitor, bound below.
   assumes the monitor's clock and its synchronous active-low reset. */
`timescale 1ns/1ns
`include "pfm_map.svh"
module pfm_monitor_checker #(
    parameter int TW = 12
) (
    input wire logic          clock_in,
    input wire logic          rst_n_in,
    input wire logic          wb_cyc_in,
    input wire logic          wb_stb_in,
    input wire logic          wb_we_in,
    input wire logic [7:0]    wb_adr_in,
    input wire logic [31:0]   wb_dat_in,
    input wire logic [31:0]   wb_dat_out,
    input wire logic          wb_ack_out,
    input wire logic [TW-1:0] temperature_in,
    input wire logic          esc_key_in,
    input wire logic          on_key_in,
    input wire logic          output_enable_out,
    input wire pfm_pkg::pfm_msg_e msg_code_out
);
    import pfm_pkg::*;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    logic       hot;
    logic [3:0] req_cnt;
    // temperature strictly above the limit
    assign hot = temperature_in > `PFM_OT_LIMIT_C;
    // reloads on any output-on request and then runs down
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || on_key_in || (wb_cyc_in && wb_stb_in && wb_we_in && wb_adr_in == `PFM_CTRL_OFS
                && wb_dat_in[`PFM_CTRL_ON])) begin
            req_cnt <= rst_n_in ? 4'hf : 4'h0;
        end else if (req_cnt != 4'h0) begin
            req_cnt <= req_cnt - 4'h1;
        end
    end
    sequence s_cool_idle;
        !output_enable_out && !hot && !on_key_in;
    endsequence
    sequence s_esc_clear;
        $rose(esc_key_in) ##1 s_cool_idle [*6];
    endsequence
    a_ack_single_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
    a_ack_answers_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("request not answered");
    a_dat_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("read data outside ack");
    a_hot_holds_off: assert property (hot [*8] |-> !output_enable_out)
        else $error("output on while hot");
    a_hot_shows_msg: assert property (hot [*8] |-> msg_code_out == PFM_MSG_OT)
        else $error("no hot message");
    a_trip_drops_out: assert property ($changed(msg_code_out)
        && msg_code_out inside {PFM_MSG_LV, PFM_MSG_LC, PFM_MSG_MS} |-> !output_enable_out)
        else $error("trip left output on");
    a_on_needs_request: assert property ($rose(output_enable_out) |-> req_cnt != 4'h0)
        else $error("output on without request");
    a_esc_clears_msg: assert property (s_esc_clear |-> msg_code_out == PFM_MSG_NONE)
        else $error("escape left message");
endmodule
bind pfm_monitor pfm_monitor_checker #(.TW(TW)) pfm_monitor_checker_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .temperature_in(temperature_in), .esc_key_in(esc_key_in),
    .on_key_in(on_key_in), .output_enable_out(output_enable_out), .msg_code_out(msg_code_out)
);

//--- tb/pfm_stage_model.sv
/* power stage model: measured values, temperature and loop mode.
   assumes set_fault is called from the bench's main process. */
`timescale 1ns/1ns
module pfm_stage_model (
    input  wire logic        clock_in,
    output logic      [15:0] meas_voltage_out,
    output logic      [15:0] meas_current_out,
    output logic      [11:0] temperature_out,
    output logic             constant_current_mode_out,
    output logic             constant_voltage_mode_out
);
    // healthy stage at time zero
    initial begin
        meas_voltage_out = 16'h03e8;
        meas_current_out = 16'h03e8;
        temperature_out = 12'h019;
        constant_current_mode_out = 1'b0;
        constant_voltage_mode_out = 1'b0;
    end
    // kinds: 0 low voltage, 1 low current, 2 current loop, 3 voltage loop, 4 hot (off sits at the limit)
    task automatic set_fault(input int kind, input logic on);
        @(posedge clock_in);
        case (kind)
            0: meas_voltage_out <= on ? 16'h000a : 16'h03e8;
            1: meas_current_out <= on ? 16'h000a : 16'h03e8;
            2: constant_current_mode_out <= on;
            3: constant_voltage_mode_out <= on;
            default: temperature_out <= on ? 12'h056 : 12'h055;
        endcase
    endtask
endmodule

//--- tb/protection_fault_monitor_test.sv
/* self-checking bench for pfm_monitor.
   assumes the stage model and a blink half-period of 4 cycles. */
`timescale 1ns/1ns
`include "pfm_map.svh"
module protection_fault_monitor_test;
    import pfm_pkg::*;
    logic        clock_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        wb_cyc_in = 1'b0;
    logic        wb_stb_in = 1'b0;
    logic        wb_we_in = 1'b0;
    logic [7:0]  wb_adr_in = 8'h00;
    logic [3:0]  wb_sel_in = 4'hf;
    logic [31:0] wb_dat_in = 32'h0;
    logic [31:0] wb_dat_out;
    logic        wb_ack_out;
    logic [15:0] meas_voltage_in;
    logic [15:0] meas_current_in;
    logic [11:0] temperature_in;
    logic        constant_current_mode_in;
    logic        constant_voltage_mode_in;
    logic        esc_key_in = 1'b0;
    logic        on_key_in = 1'b0;
    logic        output_enable_out;
    logic        buzzer_out;
    logic        msg_flash_out;
    pfm_msg_e    msg_code_out;
    logic        irq_out;
    int          num_errors = 0;
    int          num_checks = 0;
    // 50 MHz clock
    always #10 clock_in = ~clock_in;
    pfm_monitor #(.BLINK_CYCLES(4)) pfm_monitor_inst (
        .clock_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
        .wb_dat_out, .wb_ack_out, .meas_voltage_in, .meas_current_in, .temperature_in,
        .constant_current_mode_in, .constant_voltage_mode_in, .esc_key_in, .on_key_in,
        .output_enable_out, .buzzer_out, .msg_flash_out, .msg_code_out, .irq_out
    );
    pfm_stage_model pfm_stage_model_inst (
        .clock_in, .meas_voltage_out(meas_voltage_in), .meas_current_out(meas_current_in),
        .temperature_out(temperature_in), .constant_current_mode_out(constant_current_mode_in),
        .constant_voltage_mode_out(constant_voltage_mode_in)
    );
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int n = 0;
        @(posedge clock_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= adr;
        wb_dat_in <= dat;
        do begin
            @(posedge clock_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 20);
        check("ack", 1, wb_ack_out);
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, d);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb(1'b0, adr, 32'h0, d);
        check(what, exp, d);
    endtask
    task automatic press(input logic esc);
        @(posedge clock_in);
        if (esc) esc_key_in <= 1'b1;
        else on_key_in <= 1'b1;
        repeat (5) @(posedge clock_in);
        esc_key_in <= 1'b0;
        on_key_in <= 1'b0;
        repeat (8) @(posedge clock_in);
    endtask
    task automatic test_registers();
        logic [31:0] cfg [7] = '{32'h64, 32'h3, 32'h5, 32'h64, 32'h3, 32'h5, 32'h3};
        rd_chk("ctrl", `PFM_CTRL_OFS, 32'h0);
        rd_chk("status", `PFM_STATUS_OFS, 32'h0);
        rd_chk("mask", `PFM_MASK_OFS, 32'h0);
        wr(`PFM_CTRL_OFS, 32'h4c);
        rd_chk("ctrl", `PFM_CTRL_OFS, 32'hc);
        wr(`PFM_STATE_OFS, 32'hf);
        rd_chk("state", `PFM_STATE_OFS, 32'h0);
        rd_chk("unmapped", 8'h2c, 32'h0);
        for (int i = 0; i < 7; i++) begin
            wr(8'h04 + 8'(4 * i), cfg[i]);
            rd_chk("config", 8'h04 + 8'(4 * i), cfg[i]);
        end
        wr(`PFM_MASK_OFS, 32'hf);
        rd_chk("mask", `PFM_MASK_OFS, 32'hf);
    endtask
    // glitches shorter than the delay, then a held fault and an escape clear
    task automatic trip_case(input int kind, input logic [31:0] ctrl, input pfm_msg_e exp_msg, input logic trips);
        logic [1:0] b;
        wr(`PFM_CTRL_OFS, ctrl | 32'h10);
        repeat (20) @(posedge clock_in);
        check("out", 1, output_enable_out);
        repeat (2) begin
            pfm_stage_model_inst.set_fault(kind, 1'b1);
            repeat (2) @(posedge clock_in);
            pfm_stage_model_inst.set_fault(kind, 1'b0);
        end
        repeat (10) @(posedge clock_in);
        check("glitch", 1, output_enable_out);
        pfm_stage_model_inst.set_fault(kind, 1'b1);
        repeat (20) @(posedge clock_in);
        check("trip", !trips, output_enable_out);
        check("msg", trips ? exp_msg : PFM_MSG_NONE, msg_code_out);
        check("irq", trips, irq_out);
        b = {buzzer_out, msg_flash_out};
        repeat (4) @(posedge clock_in);
        check("blink", trips ? {~b} : 2'b00, {buzzer_out, msg_flash_out});
        rd_chk("stat", `PFM_STATUS_OFS, trips ? 32'h1 << (kind < 2 ? kind : 3) : 0);
        pfm_stage_model_inst.set_fault(kind, 1'b0);
        press(1'b1);
        rd_chk("clear", `PFM_STATUS_OFS, 32'h0);
        check("msg", PFM_MSG_NONE, msg_code_out);
        wr(`PFM_CTRL_OFS, 32'h20);
    endtask
    task automatic test_warm_up();
        wr(`PFM_LV_WARM_OFS, 32'h28);
        pfm_stage_model_inst.set_fault(0, 1'b1);
        wr(`PFM_CTRL_OFS, 32'h11);
        repeat (30) @(posedge clock_in);
        check("warm", 1, output_enable_out);
        repeat (30) @(posedge clock_in);
        check("late", 0, output_enable_out);
        wr(`PFM_CTRL_OFS, 32'h41);
        rd_chk("clr", `PFM_STATUS_OFS, 32'h0);
        wr(`PFM_CTRL_OFS, 32'h11);
        repeat (60) @(posedge clock_in);
        check("again", 0, output_enable_out);
        rd_chk("again", `PFM_STATUS_OFS, 32'h1);
        pfm_stage_model_inst.set_fault(0, 1'b0);
        press(1'b1);
        wr(`PFM_LV_WARM_OFS, 32'h5);
    endtask
    task automatic test_over_temp();
        wr(`PFM_MASK_OFS, 32'hb);
        wr(`PFM_CTRL_OFS, 32'h10);
        repeat (10) @(posedge clock_in);
        pfm_stage_model_inst.set_fault(4, 1'b1);
        repeat (20) @(posedge clock_in);
        check("hot", 0, output_enable_out);
        check("hot msg", PFM_MSG_OT, msg_code_out);
        check("masked", 0, irq_out);
        rd_chk("hot stat", `PFM_STATUS_OFS, 32'h4);
        wr(`PFM_CTRL_OFS, 32'h10);
        press(1'b0);
        check("refuse", 0, output_enable_out);
        pfm_stage_model_inst.set_fault(4, 1'b0);
        wr(`PFM_CTRL_OFS, 32'h40);
        press(1'b0);
        check("cooled", 1, output_enable_out);
        rd_chk("at limit", `PFM_STATUS_OFS, 32'h0);
        wr(`PFM_CTRL_OFS, 32'h20);
        wr(`PFM_MASK_OFS, 32'hf);
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clock_in);
        rst_n_in <= 1'b1;
        test_registers();
        trip_case(0, 32'h1, PFM_MSG_LV, 1'b1);
        test_warm_up();
        trip_case(1, 32'h2, PFM_MSG_LC, 1'b1);
        trip_case(2, 32'h4, PFM_MSG_MS, 1'b1);
        trip_case(3, 32'h8, PFM_MSG_MS, 1'b1);
        trip_case(2, 32'hc, PFM_MSG_MS, 1'b0);
        trip_case(3, 32'h4, PFM_MSG_MS, 1'b0);
        test_over_temp();
        end_of_test();
    end
    // watchdog
    initial begin
        #400000;
        num_errors++;
        end_of_test();
    end
endmodule
